/* File: byte_assembler.sv */
// Packs 12-bit bytes into 48-bit words, forward or reversed, with zero fill
`default_nettype none
module byte_assembler (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic en,
    // Byte side
    input wire logic byte_valid,
    input wire logic [chan_pkg::BYTE_W-1:0] byte_in,
    output logic byte_ready,
    input wire logic eor,
    input wire logic reverse,
    // Word side
    output logic word_valid,
    output wire logic [chan_pkg::WORD_W-1:0] word,
    input wire logic word_ready,
    output logic eor_done,
    output logic busy
);
    logic [1:0] cnt_r;
    logic [1:0] sel;
    logic [chan_pkg::BYTE_W-1:0] slot_r [chan_pkg::BYTES_PER_WORD];
    logic take;
    logic eor_take;
    logic full_set;
    logic flush;

    assign take = byte_valid & byte_ready & en;
    // eor_done blocks a second flush before the channel sees the first
    assign eor_take = eor & en & ~word_valid & ~take & ~eor_done;
    assign full_set = (take & (cnt_r == 2'h3)) | (eor_take & (cnt_r != 2'h0));
    assign flush = word_valid & word_ready;
    assign sel = reverse ? cnt_r : 2'h3 - cnt_r;
    assign busy = word_valid | (cnt_r != 2'h0);

    genvar k;
    generate
        for (k = 0; k < chan_pkg::BYTES_PER_WORD; k++) begin : g_slot
            assign word[k*chan_pkg::BYTE_W +: chan_pkg::BYTE_W] = slot_r[k];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    slot_r[k] <= '0;
                end else if (ce) begin
                    // Cleared after each store, so unfilled slots read zero
                    if (clr || flush) slot_r[k] <= '0;
                    else if (take && sel == 2'(k)) slot_r[k] <= byte_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 2'h0;
            word_valid <= 1'b0;
            byte_ready <= 1'b0;
            eor_done <= 1'b0;
        end else if (ce) begin
            eor_done <= eor_take & ~clr;
            if (clr) begin
                cnt_r <= 2'h0;
                word_valid <= 1'b0;
                byte_ready <= 1'b0;
            end else begin
                if (take) cnt_r <= cnt_r + 2'h1;
                else if (eor_take) cnt_r <= 2'h0;
                if (full_set) word_valid <= 1'b1;
                else if (flush) word_valid <= 1'b0;
                byte_ready <= en & ~full_set & ~eor_take & (~word_valid | word_ready);
            end
        end
    end
endmodule : byte_assembler
`default_nettype wire

/* File: chan_pkg.sv */
// Shared constants and types for the input channel
`default_nettype none
package chan_pkg;
    localparam int BYTE_W = 12;
    localparam int WORD_W = 48;
    localparam int ADDR_W = 15;
    localparam int WC_W = 15;
    localparam int CODE_W = 12;
    localparam int EQ_W = 3;
    localparam int UNIT_W = 9;
    localparam int CHAN_W = 2;
    localparam int BYTES_PER_WORD = 4;
    localparam int FIFO_DEPTH = 16;
    // Fields of the attach code
    localparam int EQ_LSB = 9;
    localparam int UNIT_LSB = 0;
    // Fields of the control word
    localparam int CW_ADDR_LSB = 0;
    localparam int CW_WC_LSB = 24;
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [WC_W-1:0] WC_RST = 15'h0000;
    // No-response limit: a least wait, so it rounds up
    localparam int CLK_PERIOD_NS = 100;
    localparam int NO_RESP_NS = 100000;
    localparam int NO_RESP_CYC = (NO_RESP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 10;
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(NO_RESP_CYC - 1);
    typedef enum logic [1:0] {
        ATTACH_INSTRUCTION,
        EQUIPMENT_FUNCTION_INSTRUCTION,
        BEGIN_INPUT_INSTRUCTION
    } op_t;
endpackage : chan_pkg
`default_nettype wire

/* File: equip_model.sv */
// Equipment controller model: answers selection and function codes, sends bytes
`default_nettype none
module equip_model #(
    parameter logic [2:0] SWITCH = 3'h2
) (
    // Clock, selection and function
    input wire logic clk,
    input wire logic sel_stb,
    input wire logic [2:0] eq_num,
    input wire logic func_stb,
    input wire logic [11:0] func,
    output logic reply,
    output logic reject,
    // Data bytes
    output logic byte_valid,
    output logic [11:0] byte_out,
    input wire logic byte_ready,
    output logic eor,
    input wire logic ch_active
);
    timeunit 1ns;
    timeprecision 1ns;
    logic on = 0, live = 0, rej = 0, took = 0, busy = 0, use_eor = 0, run = 0;
    int lag = 0, wait_n = 0, n_bytes = 0, sent = 0;
    initial {reply, reject, byte_valid, eor, byte_out} = '0;
    always @(posedge clk) took = byte_valid && byte_ready;
    always @(negedge clk) begin
        {reply, reject} = 2'h0;
        if (sel_stb) on = eq_num == SWITCH;
        if (sel_stb || func_stb) begin
            // A foreign or unattached equipment stays silent
            live = on;
            rej = busy || (func_stb && func == 12'hFFF);
            wait_n = lag + 1;
        end else if (wait_n > 0) begin
            wait_n--;
        end
        if (live && wait_n == 0) begin
            {reply, reject} = {!rej, rej};
            live = 0;
        end
        sent += int'(took);
        byte_valid = run && sent < n_bytes;
        // Idle lines toggle so a stale byte never passes for data
        byte_out = byte_valid ? 12'hA00 + 12'(sent) : ~byte_out;
        eor = run && use_eor && sent >= n_bytes && ch_active;
    end
endmodule : equip_model
`default_nettype wire

/* File: io_channel_connect_read.sv */
// One input channel: attach, function code, control-word driven input
`default_nettype none
// Notes on behaviour
// - Selection carries channel, equipment, unit fields
// - Equipment from top octal digit of code
// - Unit from three low octal digits
// - Selection held until next attach or clear
// - Each channel instance runs independently
// - Attach to busy channel rejects with jump
// - No reply within 100 us rejects attach
// - Function sends 12-bit code to attached equipment
// - Unanswered function times out into reject
// - Function to busy channel rejects with jump
// - Input to busy channel rejects; else proceed
// - Accepted input fetches control word, loads registers
// - Channel storage accesses wait for free slots
// - Input ends on count zero, end, clear
// - Partial word at end zero-filled and stored
// - Reverse signal packs bytes in reversed order
// - Reverse read restores words, reversed in storage
// - Lockout makes channel instructions illegal
// - Lockout only with interrupts on, not Category I
// - Each word: count down one, address up
// - Zero count control word never activates channel
module io_channel_connect_read #(
    parameter logic [chan_pkg::CHAN_W-1:0] CHAN_NUM = 2'h0
) (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Instruction request
    input wire logic INS_VALID,
    input wire chan_pkg::op_t INS_OP,
    input wire logic [chan_pkg::CHAN_W-1:0] INS_CHAN,
    input wire logic [chan_pkg::CODE_W-1:0] INS_CODE,
    input wire logic [chan_pkg::ADDR_W-1:0] INS_CW_ADDR,
    input wire logic [chan_pkg::ADDR_W-1:0] INS_REJ_ADDR,
    // Instruction answer
    output logic INS_READY,
    output logic INS_DONE,
    output logic INS_REJECT,
    output logic [chan_pkg::ADDR_W-1:0] JUMP_ADDR,
    output logic ILLEGAL_INT,
    // Machine mode
    input wire logic LOCKOUT,
    input wire logic INT_ACTIVE,
    input wire logic CAT1_MODE,
    input wire logic MASTER_CLEAR_PULSE,
    // Equipment selection and function
    output logic EQ_SEL_STB,
    output logic [chan_pkg::EQ_W-1:0] EQ_NUM,
    output logic [chan_pkg::UNIT_W-1:0] EQ_UNIT,
    output logic EQ_FUNC_STB,
    output logic [chan_pkg::CODE_W-1:0] EQ_FUNC,
    input wire logic EQ_REPLY,
    input wire logic EQ_REJECT,
    // Equipment data
    input wire logic EQ_BYTE_VALID,
    input wire logic [chan_pkg::BYTE_W-1:0] EQ_BYTE,
    output wire logic EQ_BYTE_READY,
    input wire logic EQ_EOR,
    input wire logic EQ_REVERSE,
    // Storage port
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [chan_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic [chan_pkg::WORD_W-1:0] MEM_WDATA,
    input wire logic MEM_GRANT,
    input wire logic [chan_pkg::WORD_W-1:0] MEM_RDATA,
    // Status
    output logic CH_ACTIVE
);
    typedef enum {C_IDLE, C_WAIT} cmd_t;
    typedef enum {X_IDLE, X_FETCH, X_RUN} xfer_t;

    cmd_t cmd_r;
    xfer_t xfer_r;
    logic [chan_pkg::TMR_W-1:0] tmr_r;
    logic [chan_pkg::WC_W-1:0] wc_r;
    logic [chan_pkg::ADDR_W-1:0] addr_r;
    logic eor_seen_r;
    logic take, illegal, busy, start, timeout, sel_take, func_take;
    logic asm_en, asm_valid, asm_eor_done, asm_busy, push, pop, finish;
    logic fifo_in_ready, fifo_valid;
    logic [chan_pkg::WORD_W-1:0] asm_word, fifo_word;
    logic [chan_pkg::WC_W-1:0] cw_wc;

    // Instructions for other channels are left to their own instances
    assign take = INS_VALID & INS_READY & (INS_CHAN == CHAN_NUM) & ~MASTER_CLEAR_PULSE;
    assign illegal = LOCKOUT & INT_ACTIVE & ~CAT1_MODE;
    assign busy = xfer_r != X_IDLE;
    assign start = take & ~illegal & ~busy & (INS_OP == chan_pkg::BEGIN_INPUT_INSTRUCTION);
    assign sel_take = take & ~illegal & ~busy & (INS_OP == chan_pkg::ATTACH_INSTRUCTION);
    assign func_take = take & ~illegal & ~busy
                       & (INS_OP == chan_pkg::EQUIPMENT_FUNCTION_INSTRUCTION);
    assign timeout = tmr_r == chan_pkg::TMR_LAST;
    assign cw_wc = MEM_RDATA[chan_pkg::CW_WC_LSB +: chan_pkg::WC_W];
    // Look ahead so ready never stands in a cycle whose byte would be refused
    assign asm_en = (xfer_r == X_RUN) & (wc_r != '0) & ~eor_seen_r & ~asm_eor_done
                    & ~(push & (wc_r == 15'h0001));
    assign push = asm_valid & fifo_in_ready;
    assign pop = fifo_valid & (xfer_r == X_RUN) & ~MEM_REQ;
    assign finish = ((wc_r == '0) | eor_seen_r) & ~fifo_valid & ~MEM_REQ & ~asm_busy;

    byte_assembler u_asm (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .clr(MASTER_CLEAR_PULSE | start),
        .en(asm_en),
        .byte_valid(EQ_BYTE_VALID),
        .byte_in(EQ_BYTE),
        .byte_ready(EQ_BYTE_READY),
        .eor(EQ_EOR),
        .reverse(EQ_REVERSE),
        .word_valid(asm_valid),
        .word(asm_word),
        .word_ready(fifo_in_ready),
        .eor_done(asm_eor_done),
        .busy(asm_busy)
    );

    word_fifo #(.WIDTH(chan_pkg::WORD_W), .DEPTH(chan_pkg::FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .clr(MASTER_CLEAR_PULSE | start),
        .in_valid(asm_valid),
        .in_data(asm_word),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_word),
        .out_ready(pop)
    );

    // Instruction sequencing and answers
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_r <= C_IDLE;
            INS_READY <= 1'b1;
            INS_DONE <= 1'b0;
            INS_REJECT <= 1'b0;
            JUMP_ADDR <= chan_pkg::ADDR_RST;
            ILLEGAL_INT <= 1'b0;
            EQ_SEL_STB <= 1'b0;
            EQ_FUNC_STB <= 1'b0;
        end else if (CE) begin
            INS_DONE <= 1'b0;
            INS_REJECT <= 1'b0;
            ILLEGAL_INT <= 1'b0;
            EQ_SEL_STB <= 1'b0;
            EQ_FUNC_STB <= 1'b0;
            if (MASTER_CLEAR_PULSE) begin
                cmd_r <= C_IDLE;
                INS_READY <= 1'b1;
            end else begin
                case (cmd_r)
                    C_IDLE: begin
                        if (take) JUMP_ADDR <= INS_REJ_ADDR;
                        if (take && illegal) begin
                            INS_DONE <= 1'b1;
                            ILLEGAL_INT <= 1'b1;
                        end else if (take && busy) begin
                            INS_DONE <= 1'b1;
                            INS_REJECT <= 1'b1;
                        end else if (sel_take || func_take) begin
                            EQ_SEL_STB <= sel_take;
                            EQ_FUNC_STB <= func_take;
                            INS_READY <= 1'b0;
                            cmd_r <= C_WAIT;
                        end else if (start) begin
                            INS_DONE <= 1'b1;
                        end
                    end
                    C_WAIT: begin
                        // Reject beats reply; silence past the limit is a reject
                        if (EQ_REPLY || EQ_REJECT || timeout) begin
                            INS_DONE <= 1'b1;
                            INS_REJECT <= EQ_REJECT | ~EQ_REPLY;
                            INS_READY <= 1'b1;
                            cmd_r <= C_IDLE;
                        end
                    end
                    default: cmd_r <= C_IDLE;
                endcase
            end
        end
    end

    // No-response timer
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) tmr_r <= '0;
        else if (CE) tmr_r <= (cmd_r == C_WAIT) ? tmr_r + chan_pkg::TMR_W'(1) : '0;
    end

    // Held selection and function code
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            EQ_NUM <= '0;
            EQ_UNIT <= '0;
            EQ_FUNC <= '0;
        end else if (CE) begin
            if (MASTER_CLEAR_PULSE) begin
                EQ_NUM <= '0;
                EQ_UNIT <= '0;
            end else if (sel_take) begin
                EQ_NUM <= INS_CODE[chan_pkg::EQ_LSB +: chan_pkg::EQ_W];
                EQ_UNIT <= INS_CODE[chan_pkg::UNIT_LSB +: chan_pkg::UNIT_W];
            end
            if (func_take) EQ_FUNC <= INS_CODE;
        end
    end

    // Transfer control and storage port; grant comes only in free storage slots
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            xfer_r <= X_IDLE;
            wc_r <= chan_pkg::WC_RST;
            addr_r <= chan_pkg::ADDR_RST;
            eor_seen_r <= 1'b0;
            CH_ACTIVE <= 1'b0;
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_ADDR <= chan_pkg::ADDR_RST;
            MEM_WDATA <= '0;
        end else if (CE) begin
            if (MASTER_CLEAR_PULSE) begin
                xfer_r <= X_IDLE;
                CH_ACTIVE <= 1'b0;
                MEM_REQ <= 1'b0;
            end else begin
                case (xfer_r)
                    X_IDLE: begin
                        if (start) begin
                            MEM_REQ <= 1'b1;
                            MEM_WE <= 1'b0;
                            MEM_ADDR <= INS_CW_ADDR;
                            eor_seen_r <= 1'b0;
                            xfer_r <= X_FETCH;
                        end
                    end
                    X_FETCH: begin
                        if (MEM_GRANT) begin
                            MEM_REQ <= 1'b0;
                            wc_r <= cw_wc;
                            addr_r <= MEM_RDATA[chan_pkg::CW_ADDR_LSB +: chan_pkg::ADDR_W];
                            CH_ACTIVE <= cw_wc != '0;
                            xfer_r <= (cw_wc != '0) ? X_RUN : X_IDLE;
                        end
                    end
                    X_RUN: begin
                        if (push) wc_r <= wc_r - 15'h0001;
                        if (asm_eor_done) eor_seen_r <= 1'b1;
                        if (MEM_REQ && MEM_GRANT) begin
                            MEM_REQ <= 1'b0;
                            addr_r <= addr_r + 15'h0001;
                        end else if (pop) begin
                            MEM_REQ <= 1'b1;
                            MEM_WE <= 1'b1;
                            MEM_ADDR <= addr_r;
                            MEM_WDATA <= fifo_word;
                        end
                        if (finish) begin
                            CH_ACTIVE <= 1'b0;
                            xfer_r <= X_IDLE;
                        end
                    end
                    default: xfer_r <= X_IDLE;
                endcase
            end
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    property p_timeout;
        CE && !MASTER_CLEAR_PULSE && cmd_r == C_WAIT && timeout && !EQ_REPLY
            |=> INS_DONE && INS_REJECT;
    endproperty
    a_timeout: assert property (p_timeout) else $error("No reject after silence");
    property p_busy_rej;
        CE && take && !illegal && busy |=> INS_DONE && INS_REJECT && JUMP_ADDR == $past(INS_REJ_ADDR);
    endproperty
    a_busy_rej: assert property (p_busy_rej) else $error("Busy channel not rejected");
    property p_read_go;
        CE && start |=> INS_DONE && !INS_REJECT ##1 1'b1;
    endproperty
    a_read_go: assert property (p_read_go) else $error("Input not accepted");
    property p_sel;
        CE && sel_take |=> EQ_SEL_STB && EQ_NUM == $past(INS_CODE[11:9])
            && EQ_UNIT == $past(INS_CODE[8:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("Selection fields wrong");
    property p_hold;
        CE && !sel_take && !MASTER_CLEAR_PULSE |=> $stable(EQ_NUM) && $stable(EQ_UNIT);
    endproperty
    a_hold: assert property (p_hold) else $error("Selection changed");
    property p_func;
        CE && func_take |=> EQ_FUNC_STB && EQ_FUNC == $past(INS_CODE) && !INS_READY;
    endproperty
    a_func: assert property (p_func) else $error("Function code not sent");
    property p_illegal;
        CE && take && illegal |=> ILLEGAL_INT && !INS_REJECT && !EQ_SEL_STB && !EQ_FUNC_STB
            && (!CH_ACTIVE || $past(busy));
    endproperty
    a_illegal: assert property (p_illegal) else $error("Lockout not honoured");
    property p_zero_cw;
        CE && xfer_r == X_FETCH && MEM_GRANT && cw_wc == '0 && !MASTER_CLEAR_PULSE
            |=> !CH_ACTIVE && xfer_r == X_IDLE;
    endproperty
    a_zero_cw: assert property (p_zero_cw) else $error("Zero count activated");
    property p_addr;
        CE && xfer_r == X_RUN && MEM_REQ && MEM_GRANT && !MASTER_CLEAR_PULSE
            |=> addr_r == $past(addr_r) + 15'h0001;
    endproperty
    a_addr: assert property (p_addr) else $error("Address not advanced");
    property p_clear;
        CE && MASTER_CLEAR_PULSE |=> !CH_ACTIVE && !MEM_REQ && INS_READY;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not stop channel");
    c_read_end: cover property (CH_ACTIVE ##1 !CH_ACTIVE);
    c_timeout: cover property (cmd_r == C_WAIT && timeout);
    c_eor_part: cover property (asm_eor_done && asm_busy);
    c_reverse: cover property (EQ_REVERSE && push);
endmodule : io_channel_connect_read
`default_nettype wire

/* File: io_channel_connect_read_tb.sv */
// Bench for the input channel: instruction answers, selection and reads
`default_nettype none
module io_channel_connect_read_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam chan_pkg::op_t AT = chan_pkg::ATTACH_INSTRUCTION;
    localparam chan_pkg::op_t FN = chan_pkg::EQUIPMENT_FUNCTION_INSTRUCTION;
    localparam chan_pkg::op_t BI = chan_pkg::BEGIN_INPUT_INSTRUCTION;
    // Mode bits are lockout, interrupts active, Category I
    typedef struct {
        chan_pkg::op_t op;
        logic [11:0] code;
        logic [2:0] mode;
        int bz, lag, rej, ill, to;
    } row_t;
    row_t rows[12] = '{
        '{AT, 12'h40F, 3'h0, 0, 0, 0, 0, 0}, '{FN, 12'h123, 3'h0, 0, 0, 0, 0, 0},
        '{FN, 12'hFFF, 3'h0, 0, 0, 1, 0, 0}, '{FN, 12'h045, 3'h0, 1, 0, 1, 0, 0},
        '{AT, 12'h403, 3'h0, 1, 0, 1, 0, 0}, '{AT, 12'h405, 3'h0, 0, 30, 0, 0, 0},
        '{AT, 12'h601, 3'h6, 0, 0, 0, 1, 0}, '{AT, 12'h601, 3'h7, 0, 0, 1, 0, 1},
        '{FN, 12'h200, 3'h4, 0, 0, 1, 0, 1}, '{AT, 12'h5FF, 3'h0, 0, 0, 0, 0, 0},
        '{BI, 12'h000, 3'h6, 0, 0, 0, 1, 0}, '{FN, 12'h077, 3'h6, 0, 0, 0, 1, 0}
    };
    chan_pkg::op_t op = AT;
    chan_pkg::op_t ops[3] = '{AT, FN, BI};
    logic clk = 0, rst_n = 0, iv = 0, lk = 0, ia = 0, c1 = 0, mc = 0, rev = 0;
    logic grant = 0, slot = 0;
    logic [1:0] ch = 2'h0;
    logic rdy, done, rej, ill, sel, fstb, reply, erej, bv, br, eor, req, we, act;
    logic [2:0] eq_num;
    logic [8:0] unit;
    logic [11:0] code = 12'h000, sel_code = 12'h000, func, eb;
    logic [14:0] rja = 15'h0000, jaddr, maddr;
    logic [47:0] rdata = 48'h0, wdata, want;
    logic [47:0] mem[64];
    int num_errors = 0, checks = 0, n;
    io_channel_connect_read dut (
        .SYS_CLK(clk), .RST_N(rst_n), .CE(1'b1), .INS_VALID(iv), .INS_OP(op),
        .INS_CHAN(ch), .INS_CODE(code), .INS_CW_ADDR(15'h0008), .INS_REJ_ADDR(rja),
        .INS_READY(rdy), .INS_DONE(done), .INS_REJECT(rej), .JUMP_ADDR(jaddr),
        .ILLEGAL_INT(ill), .LOCKOUT(lk), .INT_ACTIVE(ia), .CAT1_MODE(c1),
        .MASTER_CLEAR_PULSE(mc), .EQ_SEL_STB(sel), .EQ_NUM(eq_num), .EQ_UNIT(unit),
        .EQ_FUNC_STB(fstb), .EQ_FUNC(func), .EQ_REPLY(reply), .EQ_REJECT(erej),
        .EQ_BYTE_VALID(bv), .EQ_BYTE(eb), .EQ_BYTE_READY(br), .EQ_EOR(eor),
        .EQ_REVERSE(rev), .MEM_REQ(req), .MEM_WE(we), .MEM_ADDR(maddr),
        .MEM_WDATA(wdata), .MEM_GRANT(grant), .MEM_RDATA(rdata), .CH_ACTIVE(act)
    );
    equip_model eq (
        .clk(clk), .sel_stb(sel), .eq_num(eq_num), .func_stb(fstb), .func(func),
        .reply(reply), .reject(erej), .byte_valid(bv), .byte_out(eb), .byte_ready(br),
        .eor(eor), .ch_active(act)
    );
    initial forever #50 clk = ~clk;
    // Storage grants every other slot; the program owns the rest
    always @(negedge clk) begin
        slot = !slot;
        grant = req && slot;
        rdata = (grant && !we) ? mem[maddr[5:0]] : ~rdata;
    end
    always @(posedge clk) if (req && grant && we) mem[maddr[5:0]] = wdata;
    function automatic logic [11:0] b(input int k);
        return 12'hA00 + 12'(k);
    endfunction : b
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic issue(input chan_pkg::op_t o, input logic [11:0] c);
        @(negedge clk);
        op = o;
        code = c;
        rja = {3'h5, c};
        iv = 1;
        do @(posedge clk); while (rdy !== 1'b1);
        @(negedge clk);
        iv = 0;
        for (n = 1; done !== 1'b1 && n < 1100; n++) @(negedge clk);
        chk(done === 1'b1, "no answer");
        if (rej === 1'b1) chk(jaddr === rja, "jump address");
    endtask : issue
    task automatic start_read(input int wc, nb, input logic e, r, fin);
        for (int i = 16; i < 24; i++) mem[i] = '1;
        mem[8] = (48'(wc) << 24) | 48'h10;
        eq.n_bytes = nb;
        eq.use_eor = e;
        eq.sent = 0;
        eq.run = 1;
        rev = r;
        issue(BI, 12'h000);
        chk(rej === 1'b0 && ill === 1'b0, "input refused");
        for (n = 0; act !== 1'b1 && n < 20; n++) @(negedge clk);
        if (wc == 0) chk(act !== 1'b1, "zero count active");
        for (n = 0; fin && act !== 1'b0 && n < 600; n++) @(negedge clk);
        if (fin) begin
            chk(act === 1'b0, "channel stuck");
            eq.run = 0;
        end
    endtask : start_read
    initial begin
        repeat (2) @(negedge clk);
        chk(rdy === 1'b1 && act === 1'b0 && req === 1'b0 && eq_num === 3'h0, "reset state");
        repeat (2) @(negedge clk);
        rst_n = 1;
        foreach (rows[i]) begin
            {lk, ia, c1} = rows[i].mode;
            eq.busy = rows[i].bz != 0;
            eq.lag = rows[i].lag;
            issue(rows[i].op, rows[i].code);
            chk(rej === (rows[i].rej != 0), "reject");
            chk(ill === (rows[i].ill != 0), "illegal");
            if (rows[i].to != 0) chk(n == chan_pkg::NO_RESP_CYC + 1, "wait");
            if (rows[i].op == AT && rows[i].ill == 0) sel_code = rows[i].code;
            chk(eq_num === sel_code[11:9] && unit === sel_code[8:0], "sel");
            if (rows[i].op == FN && rows[i].ill == 0) chk(func === rows[i].code, "code");
        end
        {lk, ia, c1} = 3'h0;
        eq.busy = 0;
        eq.lag = 0;
        // A request for another channel must stay untaken by this one
        @(negedge clk);
        ch = 2'h1;
        op = AT;
        code = 12'h7C0;
        iv = 1;
        repeat (3) @(negedge clk);
        chk(rdy === 1'b1 && done === 1'b0 && eq_num === sel_code[11:9], "other channel");
        iv = 0;
        ch = 2'h0;
        start_read(2, 12, 1'b0, 1'b0, 1'b1);
        chk(mem[16] === {b(0), b(1), b(2), b(3)}, "first word");
        chk(mem[17] === {b(4), b(5), b(6), b(7)} && mem[18] === '1, "count");
        chk(eq.sent == 8, "bytes after end");
        for (int r = 0; r < 2; r++) begin
            start_read(5, 6, 1'b1, r[0], 1'b1);
            want = r ? {b(3), b(2), b(1), b(0)} : {b(0), b(1), b(2), b(3)};
            chk(mem[16] === want, "order");
            chk(mem[17] === (r ? {24'h0, b(5), b(4)} : {b(4), b(5), 24'h0}), "fill");
            chk(mem[18] === '1, "past end");
        end
        start_read(0, 4, 1'b0, 1'b0, 1'b1);
        chk(act === 1'b0 && mem[16] === '1, "zero count");
        start_read(10, 40, 1'b0, 1'b0, 1'b0);
        foreach (ops[i]) begin
            issue(ops[i], 12'h7FF);
            chk(rej === 1'b1 && n == 1, "busy");
        end
        chk(eq_num === sel_code[11:9] && unit === sel_code[8:0], "kept");
        mc = 1;
        @(negedge clk);
        mc = 0;
        chk(act === 1'b0 && req === 1'b0 && eq_num === 3'h0, "clear");
        eq.run = 0;
        stop_test();
    end
    // Two 1000-cycle silent waits dominate; the limit leaves ample room
    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end
endmodule : io_channel_connect_read_tb
`default_nettype wire

/* File: word_fifo.sv */
// Word FIFO between byte assembly and storage writes
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic wr;
    logic rd;

    assign in_ready = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rp_r];
    assign wr = in_valid & in_ready;
    assign rd = out_valid & out_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (clr) begin
                wp_r <= '0;
                rp_r <= '0;
                cnt_r <= '0;
            end else begin
                if (wr) wp_r <= wp_r + AW'(1);
                if (rd) rp_r <= rp_r + AW'(1);
                if (wr && !rd) cnt_r <= cnt_r + (AW+1)'(1);
                else if (rd && !wr) cnt_r <= cnt_r - (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && wr && !clr) mem[wp_r] <= in_data;
    end
endmodule : word_fifo
`default_nettype wire
